// file: touch_pkg.sv
/*
 * constants shared by the touch decision logic: word width, gain deltas,
 * hysteresis, consensus count, drift defaults and on-duration timing.
 * assumes a single 100 MHz clock and one processing step per burst.
 */
package touch_pkg;

  // ************************************************************
  // word width and threshold offsets
  // ************************************************************
  localparam int unsigned SIG_W = 16;
  typedef logic [SIG_W-1:0] level_t;             // one level word

  localparam level_t GAIN_HIGH_DELTA = 16'h0006; // high gain offset
  localparam level_t GAIN_LOW_DELTA  = 16'h000C; // low gain offset
  localparam int unsigned HYST_PERCENT = 17;     // dropout share of delta
  localparam level_t HYST_HIGH = SIG_W'(GAIN_HIGH_DELTA * HYST_PERCENT / 100);
  localparam level_t HYST_LOW  = SIG_W'(GAIN_LOW_DELTA * HYST_PERCENT / 100);
  localparam level_t LEVEL_MAX = 16'hFFFF;       // saturation ceiling

  // ************************************************************
  // consensus filter
  // ************************************************************
  localparam logic [1:0] INTEG_COUNT = 2'h3;     // bursts needed
  localparam logic [1:0] INTEG_RESET = 2'h0;     // counter clear value

  // ************************************************************
  // drift defaults
  // ************************************************************
  localparam level_t DRIFT_UP_STEP   = 16'h0001; // slow upward step
  localparam level_t DRIFT_DN_STEP   = 16'h0004; // fast downward step
  localparam logic [7:0] DRIFT_INTERVAL = 8'h10; // bursts per update
  localparam level_t REF_RESET       = 16'h0000; // reference after reset

  // ************************************************************
  // on-duration timing
  // ************************************************************
  localparam longint unsigned MCLK_HZ      = 100_000_000;
  localparam longint unsigned RECAL_SHORT_S = 10;
  localparam longint unsigned RECAL_LONG_S  = 60;
  localparam longint unsigned RECAL_SHORT_CYC = RECAL_SHORT_S * MCLK_HZ;
  localparam longint unsigned RECAL_LONG_CYC  = RECAL_LONG_S * MCLK_HZ;
  localparam int unsigned TIMER_W = 33;          // holds 6e9
  typedef logic [TIMER_W-1:0] timer_t;

  // ************************************************************
  // strap decode and states
  // ************************************************************
  typedef enum logic [1:0] {MODE_DC_SHORT, MODE_DC_LONG, MODE_TOGGLE, MODE_DC_INF} out_mode_e;
  typedef enum logic [1:0] {ST_CAL, ST_TRACK, ST_DETECT} det_state_e;

endpackage : touch_pkg

// file: drift_reference.sv
/*
 * reference level keeper: loads on calibration, otherwise slews slowly
 * toward the burst signal with asymmetric steps.
 * assumes burst_valid is a one-cycle strobe with burst_signal.
 */
module drift_reference
  import touch_pkg::*;
#(
  parameter touch_pkg::level_t   UP_STEP  = touch_pkg::DRIFT_UP_STEP,
  parameter touch_pkg::level_t   DN_STEP  = touch_pkg::DRIFT_DN_STEP,
  parameter logic [7:0]          INTERVAL = touch_pkg::DRIFT_INTERVAL
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // burst data
  input  wire logic              burst_valid,
  input  wire touch_pkg::level_t burst_signal,
  // control
  input  wire logic              freeze,
  input  wire logic              load,
  // result
  output touch_pkg::level_t      reference
);
  import touch_pkg::*;

  logic [7:0] burst_cnt;  // bursts since last drift step
  level_t     gap_dn;     // distance when signal is below
  level_t     gap_up;     // distance when signal is above

  assign gap_dn = reference - burst_signal;
  assign gap_up = burst_signal - reference;

  // interval counter: restarts on calibration so the first step is spaced;
  // it holds while frozen, so a wrap pending at the start of a detection
  // is not lost but taken by the first tracking burst after release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      burst_cnt <= 8'h00;
    end else if (burst_valid) begin
      if (load) begin
        burst_cnt <= 8'h00;
      end else if (!freeze) begin
        if (burst_cnt == INTERVAL - 8'h01) begin
          burst_cnt <= 8'h00;
        end else begin
          burst_cnt <= burst_cnt + 8'h01;
        end
      end
    end
  end

  // reference update; steps never overshoot the signal
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reference <= REF_RESET;
    end else if (burst_valid) begin
      if (load) begin
        reference <= burst_signal;
      end else if (!freeze && burst_cnt == INTERVAL - 8'h01) begin
        if (burst_signal < reference) begin
          reference <= (gap_dn > DN_STEP) ? reference - DN_STEP : burst_signal;
        end else if (burst_signal > reference) begin
          reference <= (gap_up > UP_STEP) ? reference + UP_STEP : burst_signal;
        end
      end
    end
  end

endmodule : drift_reference

// file: touch_detector.sv
/*
 * touch decision logic: threshold against a drifting reference,
 * hysteresis release, three-burst consensus, max on-duration recalibration
 * and dc or toggle output.
 * assumes raw burst values arrive as a one-cycle strobe, straps are
 * static levels synchronous to mclk, and rst_n is the power-up reset.
 */
module touch_detector
  import touch_pkg::*;
#(
  parameter longint unsigned SHORT_CYC = touch_pkg::RECAL_SHORT_CYC, // 10 s of mclk
  parameter longint unsigned LONG_CYC  = touch_pkg::RECAL_LONG_CYC,  // 60 s of mclk
  parameter touch_pkg::level_t UP_STEP  = touch_pkg::DRIFT_UP_STEP,
  parameter touch_pkg::level_t DN_STEP  = touch_pkg::DRIFT_DN_STEP,
  parameter logic [7:0]        INTERVAL = touch_pkg::DRIFT_INTERVAL
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // straps
  input  wire logic              gain_high_strap,
  input  wire logic              mode_strap_a,
  input  wire logic              mode_strap_b,
  // burst acquisition
  input  wire logic              burst_valid,
  input  wire touch_pkg::level_t burst_signal,
  // results
  output logic                   detect_out,
  output logic                   recal_pulse,
  output touch_pkg::level_t      reference_level
);
  import touch_pkg::*;

  // ************************************************************
  // strap capture
  // ************************************************************
  logic       straps_taken;  // set once after reset release
  logic       gain_high;     // latched gain choice
  out_mode_e  out_mode;      // latched output mode

  // straps read on the first clock after power-up and never again;
  // a strap moved later has no effect until the next reset, so a
  // board that rewires straps live must also pulse rst_n
  // straps_taken also gates calibration, so a burst that lands on the
  // capture edge cannot calibrate against the wrong gain
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      straps_taken <= 1'b0;
      gain_high    <= 1'b0;
      out_mode     <= MODE_DC_SHORT;
    end else if (!straps_taken) begin
      straps_taken <= 1'b1;
      gain_high    <= gain_high_strap;
      case ({mode_strap_a, mode_strap_b})
        2'b11:   out_mode <= MODE_DC_SHORT;
        2'b10:   out_mode <= MODE_DC_LONG;
        2'b00:   out_mode <= MODE_TOGGLE;
        default: out_mode <= MODE_DC_INF;
      endcase
    end
  end

  // ************************************************************
  // threshold and release levels
  // ************************************************************
  level_t     delta;        // threshold offset
  level_t     hyst;         // dropout below threshold
  logic [SIG_W:0] thr_wide; // unsaturated threshold
  level_t     threshold;    // saturated threshold
  level_t     release_lvl;  // release when signal below this
  logic       over_thr;     // burst reaches or exceeds threshold
  logic       below_rel;    // burst far enough under threshold

  assign delta       = gain_high ? GAIN_HIGH_DELTA : GAIN_LOW_DELTA;
  assign hyst        = gain_high ? HYST_HIGH : HYST_LOW;
  assign thr_wide    = {1'b0, reference_level} + {1'b0, delta};
  // hysteresis is a floor of 17 percent of delta, so 1 count at high
  // gain and 2 counts at low gain; release compares strictly below
  // threshold - hyst, and a burst sitting exactly on that level holds
  // saturation keeps a high reference from wrapping to a tiny threshold
  assign threshold   = thr_wide[SIG_W] ? LEVEL_MAX : thr_wide[SIG_W-1:0];
  assign release_lvl = threshold - hyst;
  assign over_thr    = burst_signal >= threshold;
  assign below_rel   = burst_signal < release_lvl;

  // ************************************************************
  // detection state machine
  // ************************************************************
  det_state_e state;        // calibrate, track or detect
  logic [1:0] integ;        // consensus counter
  logic       timeout_hit;  // max on-duration reached
  logic       cal_load;     // reference takes this burst

  // calibration takes the first accepted burst after reset or after a
  // timeout; until then the reference is not trusted, so no compare is
  // made and the drift counter restarts with the load
  assign cal_load = burst_valid && state == ST_CAL && straps_taken;

  // consensus counter restarts on any burst without detection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      integ <= INTEG_RESET;
    end else if (burst_valid) begin
      if (state != ST_TRACK || !over_thr) begin
        integ <= INTEG_RESET;
      end else if (integ == INTEG_COUNT - 2'h1) begin
        integ <= INTEG_RESET;
      end else begin
        integ <= integ + 2'h1;
      end
    end
  end

  // state: a timeout wins over a burst in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_CAL;
    end else begin
      case (state)
        ST_CAL: begin
          if (cal_load) begin
            state <= ST_TRACK;
          end
        end
        ST_TRACK: begin
          if (burst_valid && over_thr && integ == INTEG_COUNT - 2'h1) begin
            state <= ST_DETECT;
          end
        end
        ST_DETECT: begin
          if (timeout_hit) begin
            state <= ST_CAL;
          end else if (burst_valid && below_rel) begin
            state <= ST_TRACK;
          end
        end
        default: begin
          state <= ST_CAL;
        end
      endcase
    end
  end

  // ************************************************************
  // max on-duration timer
  // ************************************************************
  timer_t on_cnt;     // cycles spent in detection
  timer_t on_limit;   // selected limit
  logic   timer_on;   // limit is finite

  assign on_limit = (out_mode == MODE_DC_LONG) ? TIMER_W'(LONG_CYC) : TIMER_W'(SHORT_CYC);
  assign timer_on = out_mode != MODE_DC_INF;
  assign timeout_hit = timer_on && state == ST_DETECT && on_cnt == on_limit - TIMER_W'(1);

  // counts only while detecting; cleared otherwise
  // the counter restarts with every new detection, so a release just
  // before the limit gives the next touch the full on-duration again;
  // in the infinite mode it still runs but timeout_hit is masked
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      on_cnt <= '0;
    end else if (state == ST_DETECT && !timeout_hit) begin
      on_cnt <= on_cnt + TIMER_W'(1);
    end else begin
      on_cnt <= '0;
    end
  end

  // one-cycle marker of a timeout recalibration
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      recal_pulse <= 1'b0;
    end else begin
      recal_pulse <= timeout_hit;
    end
  end

  // ************************************************************
  // output
  // ************************************************************
  // dc follows the detection; toggle flips on each new detection and
  // keeps its state through a timeout
  // the deciding burst is recognised here from the same terms that move
  // the state, so the output changes on the very edge that enters
  // detection rather than one cycle later
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      detect_out <= 1'b0;
    end else if (out_mode == MODE_TOGGLE) begin
      if (state == ST_TRACK && burst_valid && over_thr && integ == INTEG_COUNT - 2'h1) begin
        detect_out <= !detect_out;
      end
    end else if (timeout_hit) begin
      detect_out <= 1'b0;
    end else if (state == ST_TRACK && burst_valid && over_thr && integ == INTEG_COUNT - 2'h1) begin
      detect_out <= 1'b1;
    end else if (state == ST_DETECT && burst_valid && below_rel) begin
      detect_out <= 1'b0;
    end
  end

  // ************************************************************
  // reference keeper
  // ************************************************************
  // the keeper is frozen outside tracking, which covers both the
  // calibrate wait and an active detection; its interval counter holds
  // too, so drift timing resumes where it stopped after a release
  // the deciding burst itself is still a tracking burst and may step
  // the reference on the edge that enters detection
  drift_reference #(
    .UP_STEP  (UP_STEP),
    .DN_STEP  (DN_STEP),
    .INTERVAL (INTERVAL)
  ) u_drift (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .burst_valid  (burst_valid),
    .burst_signal (burst_signal),
    .freeze       (state != ST_TRACK),
    .load         (cal_load),
    .reference    (reference_level)
  );

endmodule : touch_detector

// file: touch_detector_checker.sv
/* timing checks for the touch decision logic, bound to touch_detector.
   assumes straps stay put at the first edge after reset, where they are captured here. */
module touch_detector_checker
  import touch_pkg::*;
(
  // clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  // straps
  input wire logic              gain_high_strap,
  input wire logic              mode_strap_a,
  input wire logic              mode_strap_b,
  // bursts
  input wire logic              burst_valid,
  input wire touch_pkg::level_t burst_signal,
  // results
  input wire logic              detect_out,
  input wire logic              recal_pulse,
  input wire touch_pkg::level_t reference_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************
  // helper logic
  // ************
  logic        first, g_q, a_q, b_q, cal_pend;   // strap copies, calibration due
  logic [1:0]  hits;                             // successive hit bursts
  logic [16:0] thr, lvl;                         // widened so no wrap hides a miss
  logic        hit, drop, dc;
  assign thr  = {1'b0, reference_level} + (g_q ? 17'h00006 : 17'h0000C);
  assign lvl  = {1'b0, burst_signal};
  assign hit  = burst_valid && (lvl >= thr);
  assign drop = burst_valid && (lvl + (g_q ? 17'h00001 : 17'h00002) < thr);
  assign dc   = a_q | b_q;                       // toggle is the only 00 mode
  // straps copied once, as the device does
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      first <= 1'b1; g_q <= 1'b0; a_q <= 1'b0; b_q <= 1'b0;
    end else if (first) begin
      first <= 1'b0; g_q <= gain_high_strap; a_q <= mode_strap_a; b_q <= mode_strap_b;
    end
  end
  // a hit run; cleared while detecting, so each detection needs a fresh run
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) hits <= 2'h0;
    else if (detect_out) hits <= 2'h0;
    else if (burst_valid) hits <= hit ? ((hits == 2'h3) ? 2'h3 : hits + 2'h1) : 2'h0;
  end
  // next burst after reset or timeout reloads the reference in one jump
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cal_pend <= 1'b1;
    else if (recal_pulse) cal_pend <= 1'b1;
    else if (burst_valid) cal_pend <= 1'b0;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ************
  // properties
  // ************
  property p_rise; dc && $rose(detect_out) |-> $past(hit) && ($past(hits) >= 2'h2); endproperty
  property p_fall; dc && $fell(detect_out) |-> $past(drop) or (##[0:1] recal_pulse); endproperty
  property p_hold; dc && $past(detect_out) && !$past(drop) |-> detect_out or (##[0:1] recal_pulse); endproperty
  property p_frozen; dc && detect_out && $past(detect_out) |-> $stable(reference_level); endproperty
  property p_pulse; recal_pulse |=> !recal_pulse; endproperty
  property p_dc_off; dc && recal_pulse |-> !detect_out; endproperty
  property p_src; dc && recal_pulse |-> $past(detect_out) || $past(detect_out, 2); endproperty
  property p_inf; !first && !a_q && b_q |-> !recal_pulse; endproperty
  property p_slew;
    burst_valid && !cal_pend && !recal_pulse |=> ({1'b0, reference_level} <= {1'b0, $past(reference_level)} + 17'h1)
      && ({1'b0, reference_level} + 17'h4 >= {1'b0, $past(reference_level)});
  endproperty
  a_rise: assert property (p_rise) else $error("detect rose without three hits");
  a_fall: assert property (p_fall) else $error("detect fell above release level");
  a_hold: assert property (p_hold) else $error("detect dropped too early");
  a_frozen: assert property (p_frozen) else $error("reference moved while detecting");
  a_pulse: assert property (p_pulse) else $error("recal pulse too long");
  a_dc_off: assert property (p_dc_off) else $error("output kept after timeout");
  a_src: assert property (p_src) else $error("recal without detection");
  a_inf: assert property (p_inf) else $error("recal in infinite mode");
  a_slew: assert property (p_slew) else $error("reference stepped too far");
  c_rise: cover property ($rose(detect_out));
  c_recal: cover property (recal_pulse);
  c_rel: cover property (dc && $fell(detect_out) && $past(drop));
endmodule : touch_detector_checker
bind touch_detector touch_detector_checker i_chk (.mclk(mclk), .rst_n(rst_n), .gain_high_strap(gain_high_strap),
  .mode_strap_a(mode_strap_a), .mode_strap_b(mode_strap_b), .burst_valid(burst_valid),
  .burst_signal(burst_signal), .detect_out(detect_out), .recal_pulse(recal_pulse), .reference_level(reference_level));

// file: electrode_model.sv
/* sense electrode stand-in: hands one burst word per request after a random pause.
   assumes the caller enters send just after a rising edge. */
module electrode_model
  import touch_pkg::*;
(
  // clock
  input wire logic         mclk,
  // burst output
  output touch_pkg::level_t burst_signal,
  output logic              burst_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    burst_valid  = 1'b0;
    burst_signal = 16'h0000;
  end
  // word is inverted once stale so an old sample never looks fresh
  task automatic send(input level_t v);
    repeat (1 + $urandom_range(2)) @(posedge mclk);
    burst_valid  <= 1'b1;
    burst_signal <= v;
    @(posedge mclk);
    burst_valid  <= 1'b0;
    burst_signal <= ~v;
    #1;
  endtask : send
endmodule : electrode_model

// file: touch_threshold_drift_tracker_tb_top.sv
/* self-checking bench: integer model of the touch decision compared at every burst.
   assumes electrode_model supplies bursts and short timeouts stand in for seconds. */
module touch_threshold_drift_tracker_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import touch_pkg::*;
  localparam longint unsigned S_CYC = 50;   // short timeout, cycles
  localparam longint unsigned L_CYC = 200;  // long timeout, cycles
  localparam logic [7:0]      INTV  = 8'h04;
  localparam int UP = 1;
  localparam int DN = 4;
  logic   mclk, rst_n, gain, sa, sb, bv, rp, det;
  level_t bs, rl;
  int     err_count, tests_run, m_ref, m_st, m_int, m_dc, m_det, m_tmr, m_dl, m_hy, m_tmo, m_tog, v, th;
  bit     chk;
  logic [2:0] cfg [4] = '{3'h7, 3'h2, 3'h4, 3'h1};  // {gain, a, b}
  touch_detector #(.SHORT_CYC(S_CYC), .LONG_CYC(L_CYC), .INTERVAL(INTV)) i_dut (.mclk(mclk), .rst_n(rst_n),
    .gain_high_strap(gain), .mode_strap_a(sa), .mode_strap_b(sb), .burst_valid(bv), .burst_signal(bs),
    .detect_out(det), .recal_pulse(rp), .reference_level(rl));
  electrode_model i_el (.mclk(mclk), .burst_signal(bs), .burst_valid(bv));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // reference model; state 0 calibrate, 1 track, 2 detect
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      m_ref = 0; m_st = 0; m_det = 0; m_int = 0; m_dc = 0;
      m_dl = gain ? 6 : 12; m_hy = m_dl * 17 / 100;
      m_tog = !sa && !sb; m_tmo = (sa == sb) ? int'(S_CYC) : (sa ? int'(L_CYC) : 0);
    end else begin
      th = (m_ref + m_dl > 65535) ? 65535 : m_ref + m_dl;
      if (m_st == 2 && m_tmo != 0 && ++m_tmr >= m_tmo) begin
        m_st = 0;
        if (!m_tog) m_det = 0;
      end else if (bv) begin
        v = bs; chk = 1;
        if (m_st == 0) begin
          m_ref = v; m_st = 1; m_int = 0; m_dc = 0;
        end else if (m_st == 2) begin
          if (v + m_hy < th) begin
            m_st = 1;
            if (!m_tog) m_det = 0;
          end
        end else begin
          // tracking: every burst counts toward drift, the deciding one too
          m_int = (v >= th) ? m_int + 1 : 0;
          if (m_int == 3) begin
            m_st = 2; m_tmr = 0; m_int = 0; m_det = m_tog ? !m_det : 1;
          end
          if (++m_dc == int'(INTV)) begin
            m_dc = 0;
            if (v > m_ref) m_ref += (v - m_ref < UP) ? v - m_ref : UP;
            else m_ref -= (m_ref - v < DN) ? m_ref - v : DN;
          end
        end
      end
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  // results settle by the falling edge after a burst
  always @(negedge mclk) if (chk) begin
    chk = 0;
    check(rl, 16'(m_ref));
    check({15'h0, det}, 16'(m_det));
  end
  task automatic final_report();
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic run_seq();
    int t;
    gain <= ~gain;
    i_el.send(16'h0064);
    repeat (8) i_el.send(16'h005A);
    repeat (8) i_el.send(16'(m_ref + 2));
    foreach (cfg[k]) i_el.send(16'(m_ref + m_dl - (k == 2)));
    repeat (3) i_el.send(16'(m_ref + m_dl + 40));
    i_el.send(16'(m_ref + m_dl - m_hy));
    i_el.send(16'(m_ref + m_dl - m_hy - 1));
    repeat (3) i_el.send(16'(m_ref + m_dl + 9));
    for (t = 0; t < 400 && rp !== 1'b1; t++) @(posedge mclk);
    check({15'h0, t < 400}, {15'h0, m_tmo != 0});
    #1 check({15'h0, det}, 16'(m_det));
    i_el.send(16'h007B);
    repeat (40) i_el.send(16'(m_ref + $urandom_range(30) - 10));
  endtask : run_seq
  initial begin
    rst_n = 1'b0; gain = 1'b1; sa = 1'b1; sb = 1'b1; err_count = 0; tests_run = 0; chk = 0;
    void'($urandom(32'hac7cc493));
    for (int c = 0; c < 4; c++) begin
      @(posedge mclk);
      rst_n <= 1'b0;
      {gain, sa, sb} <= cfg[c];
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      run_seq();
    end
    final_report();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("CHECK FAILED t=%0t run hung", $time);
    final_report();
  end
endmodule : touch_threshold_drift_tracker_tb_top
